// ==== hdl/ist_pkg.sv ====
// Contract
// - Outside idle sleep, own or general call address still matches from bus clock.
// - After a wake-up match, SCL is held low until software clears int_flag.
// - After waking from deep sleep the data register need not hold the bus byte.
// - Own address with read bit acknowledged gives status 0xA8; a clear ack_enable marks last.
// - Lost arbitration then read-addressed: acknowledge and report status 0xB0.
// - Byte sent and ACK received gives status 0xB8; next byte follows.
// - Byte sent and NACK received gives 0xC0; then not addressed after flag clear.
// - ACK after a last byte gives status 0xC8; then not addressed slave state.
// - Not addressed: own address recognised with ack_enable, general call also needs enable.
// - A start_request left set makes the block generate START once the bus is free.
// - While int_flag is clear the status register reads 0xF8.
// - START or STOP inside a byte or acknowledge is a bus error, status 0x00.
// - Bus error recovery: stop_request plus flag clear, release lines, clear stop only. Here the flag clear alone recovers; stop_request is not needed.
// - Address register holds own address in bits 7..1 and general call enable bit 0.
// - Read direction bit selects transmit operation; write selects receive operation.
// - After the final byte SDA stays released, so the master reads all ones.
package ist_pkg;

	// Timing of the generated START.
	localparam int CLK_PERIOD_NS  = 4;
	localparam int START_HOLD_NS  = 600;
	localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] START_HOLD_LOAD = 8'(START_HOLD_CYC - 1);

	// Register word indices; byte address is four times the index.
	localparam logic [2:0] ADR_CONTROL  = 3'h0;
	localparam logic [2:0] ADR_STATUS   = 3'h1;
	localparam logic [2:0] ADR_ADDRESS  = 3'h2;
	localparam logic [2:0] ADR_DATA     = 3'h3;
	localparam logic [2:0] ADR_IRQ_STAT = 3'h4;
	localparam logic [2:0] ADR_IRQ_MASK = 3'h5;

	// Reset values.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'hff;
	localparam logic [1:0] PRESC_RESET = 2'h0;

	// Status codes and status register layout.
	localparam logic [7:0] ST_ADDR_READ = 8'ha8;
	localparam logic [7:0] ST_ARB_READ  = 8'hb0;
	localparam logic [7:0] ST_DATA_ACK  = 8'hb8;
	localparam logic [7:0] ST_DATA_NACK = 8'hc0;
	localparam logic [7:0] ST_LAST_ACK  = 8'hc8;
	localparam logic [7:0] ST_NO_INFO   = 8'hf8;
	localparam logic [7:0] ST_BUS_ERR   = 8'h00;
	localparam logic [7:0] CODE_MASK    = 8'hf8;

	localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT  = 4'h7;

	// Interrupt status bits.
	localparam int IRQ_W    = 2;
	localparam int IRQ_FLAG = 0;
	localparam int IRQ_BERR = 1;

	typedef struct packed {
		logic       int_flag;
		logic       ack_enable;
		logic       start_request;
		logic       stop_request;
		logic       rsv_3;
		logic       enable;
		logic [1:0] rsv_1_0;
	} ist_ctrl_t;

	typedef struct packed {
		logic [6:0] own_slave_address;
		logic       general_call_enable;
	} ist_addr_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} ist_line_t;

	typedef enum logic [3:0] {
		S_IDLE      = 4'b0000,
		S_ADDR      = 4'b0001,
		S_ADDR_ACK  = 4'b0011,
		S_WAIT_LOAD = 4'b0010,
		S_TX        = 4'b0110,
		S_TX_ACK    = 4'b0111,
		S_WAIT_END  = 4'b0101,
		S_IGNORE    = 4'b0100,
		S_BERR      = 4'b1100,
		S_GEN       = 4'b1101,
		S_MHOLD     = 4'b1111
	} ist_state_t;

endpackage : ist_pkg

// ==== hdl/ist_slave_tx.sv ====
module ist_slave_tx import ist_pkg::*; (
	input  logic        clk_i,
	input  logic        rst_i,
	input  logic        wb_cyc_i,
	input  logic        wb_stb_i,
	input  logic        wb_we_i,
	input  logic [4:0]  wb_adr_i,
	input  logic [3:0]  wb_sel_i,
	input  logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic        wb_ack_o,
	output logic        irq_o,
	input  logic        scl_i,
	output logic        scl_o,
	output logic        scl_oe_n_o,
	input  logic        sda_i,
	output logic        sda_o,
	output logic        sda_oe_n_o,
	input  logic        sleep_i,
	input  logic        arb_lost_i,
	output logic        wake_o,
	output logic        rx_select_o,
	output logic        master_start_o
);

	ist_line_t  line_f;
	ist_line_t  line_q;
	ist_ctrl_t  ctrl;
	ist_ctrl_t  next_ctrl;
	ist_ctrl_t  wr_ctrl_data;
	ist_addr_t  addr_reg;
	ist_state_t state;
	ist_state_t next_state;
	logic [7:0]       data_reg;
	logic [7:0]       status_code;
	logic [1:0]       presc;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_evt;
	logic [3:0]       bit_cnt;
	logic [7:0]       shreg;
	logic [7:0]       hold_cnt;
	logic             last_byte;
	logic             master_ack;
	logic             arb_pend;
	logic             busy;
	logic             scl_hold_q;

	// Bus lines pass the three-stage synchroniser.
	ist_sync3 #(
		.WIDTH(2)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({scl_i, sda_i}),
		.sync_o  (line_f)
	);

	// Matches a register index.
	function automatic logic hit(input logic [2:0] idx, input logic [2:0] reg_idx);
		return idx == reg_idx;
	endfunction : hit

	// Line events.
	wire scl_rise   = line_f.scl & ~line_q.scl;
	wire scl_fall   = ~line_f.scl & line_q.scl;
	wire start_cond = line_f.scl & line_q.scl & line_q.sda & ~line_f.sda;
	wire stop_cond  = line_f.scl & line_q.scl & ~line_q.sda & line_f.sda;

	// Register bus decode; writes land at the edge where the master sees ack.
	wire       wb_req   = wb_cyc_i & wb_stb_i;
	wire [2:0] wb_idx   = wb_adr_i[4:2];
	wire       wb_wr    = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
	wire       wr_ctrl  = wb_wr & hit(wb_idx, ADR_CONTROL);
	wire       wr_stat  = wb_wr & hit(wb_idx, ADR_STATUS);
	wire       wr_addr  = wb_wr & hit(wb_idx, ADR_ADDRESS);
	wire       wr_data  = wb_wr & hit(wb_idx, ADR_DATA);
	wire       wr_istat = wb_wr & hit(wb_idx, ADR_IRQ_STAT);
	wire       wr_imask = wb_wr & hit(wb_idx, ADR_IRQ_MASK);
	assign wr_ctrl_data = wb_dat_i[7:0];

	// Status reads no-information whenever the flag is clear.
	wire [7:0] code_shown = ctrl.int_flag ? status_code : ST_NO_INFO;
	wire [7:0] status_rd  = (code_shown & CODE_MASK) | {6'h00, presc};

	// Read data selection; unmapped words read zero.
	wire [7:0] rd_byte =
		hit(wb_idx, ADR_CONTROL)  ? ctrl :
		hit(wb_idx, ADR_STATUS)   ? status_rd :
		hit(wb_idx, ADR_ADDRESS)  ? addr_reg :
		hit(wb_idx, ADR_DATA)     ? data_reg :
		hit(wb_idx, ADR_IRQ_STAT) ? {6'h00, irq_stat} :
		hit(wb_idx, ADR_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;

	// Address recognition gated by ack_enable and general call enable.
	wire own_hit   = shreg[7:1] == addr_reg.own_slave_address;
	wire gc_hit    = (shreg[7:1] == GENERAL_CALL_ADDRESS) & addr_reg.general_call_enable;
	wire read_hit  = ctrl.ack_enable & own_hit & shreg[0];
	wire write_hit = ctrl.ack_enable & (own_hit | gc_hit) & ~shreg[0];
	wire addr_done = (state == S_ADDR) & scl_fall & (bit_cnt == BYTE_BITS);

	// START or STOP inside an address byte, data byte or acknowledge.
	wire in_frame = ((state == S_ADDR) & (bit_cnt != 4'h0)) | (state == S_ADDR_ACK) |
		(state == S_TX) | (state == S_TX_ACK);
	wire berr_evt = ctrl.enable & (start_cond | stop_cond) & in_frame;

	// Events that set the interrupt flag, and their status codes.
	wire ack_done = (state == S_ADDR_ACK) & scl_fall;
	wire tx_done  = (state == S_TX_ACK) & scl_fall;
	wire set_int  = ctrl.enable & (ack_done | tx_done | berr_evt);
	wire [7:0] evt_code =
		berr_evt ? ST_BUS_ERR :
		ack_done ? (arb_pend ? ST_ARB_READ : ST_ADDR_READ) :
		~master_ack ? ST_DATA_NACK :
		last_byte ? ST_LAST_ACK : ST_DATA_ACK;

	// Software clearing the flag releases a waiting state; a new set wins.
	wire sw_release = wr_ctrl & wr_ctrl_data.int_flag & ctrl.int_flag & ~set_int;
	wire in_wait    = (state == S_WAIT_LOAD) | (state == S_WAIT_END);
	wire tx_start   = (state == S_WAIT_LOAD) & (next_state == S_TX);

	// Next state of the bus sequencer.
	always_comb begin
		next_state = state;
		if (!ctrl.enable) begin
			next_state = S_IDLE;
		end else if (berr_evt) begin
			next_state = S_BERR;
		end else if (start_cond && state != S_GEN && state != S_MHOLD && state != S_BERR) begin
			next_state = S_ADDR;
		end else if (stop_cond && (state == S_ADDR || state == S_IGNORE)) begin
			next_state = S_IDLE;
		end else begin
			case (state)
				S_IDLE: begin
					if (ctrl.start_request && !busy) begin
						next_state = S_GEN;
					end
				end
				S_ADDR: begin
					if (addr_done) begin
						next_state = read_hit ? S_ADDR_ACK : S_IGNORE;
					end
				end
				S_ADDR_ACK: begin
					if (scl_fall) begin
						next_state = S_WAIT_LOAD;
					end
				end
				S_WAIT_LOAD: begin
					if (sw_release) begin
						next_state = S_TX;
					end
				end
				S_TX: begin
					if (scl_fall && bit_cnt == LAST_BIT) begin
						next_state = S_TX_ACK;
					end
				end
				S_TX_ACK: begin
					if (scl_fall) begin
						next_state = (master_ack && !last_byte) ? S_WAIT_LOAD : S_WAIT_END;
					end
				end
				S_WAIT_END: begin
					if (sw_release) begin
						next_state = busy ? S_IGNORE : S_IDLE;
					end
				end
				S_IGNORE: begin
					next_state = S_IGNORE;
				end
				S_BERR: begin
					if (sw_release) begin
						next_state = S_IDLE;
					end
				end
				S_GEN: begin
					if (hold_cnt == 8'h00) begin
						next_state = S_MHOLD;
					end
				end
				S_MHOLD: begin
					if (ctrl.stop_request) begin
						next_state = S_IDLE;
					end
				end
				default: begin
					next_state = S_IDLE;
				end
			endcase
		end
	end

	// Control register: software writes, flag clears by a one, hardware set wins.
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl          = wr_ctrl_data;
			next_ctrl.rsv_3    = 1'b0;
			next_ctrl.rsv_1_0  = 2'h0;
			next_ctrl.int_flag = ctrl.int_flag & ~wr_ctrl_data.int_flag;
		end
		if (set_int) begin
			next_ctrl.int_flag = 1'b1;
		end
		if (state == S_BERR && sw_release) begin
			next_ctrl.stop_request = 1'b0;
		end
		if (state == S_MHOLD && ctrl.stop_request) begin
			next_ctrl.stop_request = 1'b0;
		end
		if (state == S_GEN && next_state == S_MHOLD) begin
			next_ctrl.start_request = 1'b0;
		end
	end

	// Line drive: SDA low for acknowledge, zero data bits and START; SCL low while waiting.
	wire drive_sda = (state == S_ADDR_ACK) | ((state == S_TX) & ~shreg[7]) |
		(state == S_GEN) | (state == S_MHOLD);
	wire drive_scl = in_wait | (state == S_MHOLD);

	// Software visible registers and sequencer state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= CTRL_RESET;
			addr_reg <= ADDR_RESET;
			presc    <= PRESC_RESET;
			irq_mask <= '0;
			state    <= S_IDLE;
			line_q   <= 2'h3;
		end else begin
			ctrl   <= next_ctrl;
			state  <= next_state;
			line_q <= line_f;
			if (wr_addr) begin
				addr_reg <= wb_dat_i[7:0];
			end
			if (wr_stat) begin
				presc <= wb_dat_i[1:0];
			end
			if (wr_imask) begin
				irq_mask <= wb_dat_i[IRQ_W-1:0];
			end
		end
	end

	// Data register: software loads, the matched address lands only when awake.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_reg <= DATA_RESET;
		end else if (wr_data) begin
			data_reg <= wb_dat_i[7:0];
		end else if (addr_done && (read_hit || write_hit) && !sleep_i) begin
			data_reg <= shreg;
		end
	end

	// Shift register and bit counter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shreg   <= 8'h00;
			bit_cnt <= 4'h0;
		end else if (next_state == S_ADDR && state != S_ADDR) begin
			bit_cnt <= 4'h0;
		end else if (state == S_ADDR && scl_rise) begin
			shreg   <= {shreg[6:0], line_f.sda};
			bit_cnt <= bit_cnt + 4'h1;
		end else if (tx_start) begin
			shreg   <= data_reg;
			bit_cnt <= 4'h0;
		end else if (state == S_TX && scl_fall) begin
			shreg   <= {shreg[6:0], 1'b1};
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// Transfer bookkeeping: last byte mark, master answer, arbitration and bus busy.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_byte  <= 1'b0;
			master_ack <= 1'b0;
			arb_pend   <= 1'b0;
			busy       <= 1'b0;
		end else begin
			if (tx_start) begin
				last_byte <= ~wr_ctrl_data.ack_enable;
			end
			if (state == S_TX_ACK && scl_rise) begin
				master_ack <= ~line_f.sda;
			end
			if (arb_lost_i) begin
				arb_pend <= 1'b1;
			end else if (ack_done || stop_cond) begin
				arb_pend <= 1'b0;
			end
			if (start_cond) begin
				busy <= 1'b1;
			end else if (stop_cond) begin
				busy <= 1'b0;
			end
		end
	end

	// Status code, START hold counter and interrupt status.
	assign irq_evt = {berr_evt, set_int};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_code <= ST_NO_INFO;
			hold_cnt    <= START_HOLD_LOAD;
			irq_stat    <= '0;
		end else begin
			if (set_int) begin
				status_code <= evt_code;
			end
			hold_cnt <= (state == S_GEN) ? hold_cnt - 8'h01 : START_HOLD_LOAD;
			irq_stat <= (irq_stat & ~(wr_istat ? wb_dat_i[IRQ_W-1:0] : '0)) | irq_evt;
		end
	end

	// Registered outputs: lines, bus answer, interrupt, wake level and hand-off pulses.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_o          <= 1'b0;
			sda_o          <= 1'b0;
			scl_oe_n_o     <= 1'b1;
			sda_oe_n_o     <= 1'b1;
			scl_hold_q     <= 1'b0;
			wb_ack_o       <= 1'b0;
			wb_dat_o       <= 32'h0000_0000;
			irq_o          <= 1'b0;
			wake_o         <= 1'b0;
			rx_select_o    <= 1'b0;
			master_start_o <= 1'b0;
		end else begin
			scl_o          <= 1'b0;
			sda_o          <= 1'b0;
			scl_hold_q     <= drive_scl;
			sda_oe_n_o     <= ~drive_sda;
			scl_oe_n_o     <= ~(drive_scl | scl_hold_q); // SDA settles before SCL is freed.
			wb_ack_o       <= wb_req & ~wb_ack_o;
			wb_dat_o       <= (wb_req & ~wb_ack_o) ? {24'h00_0000, rd_byte} : wb_dat_o;
			irq_o          <= |(irq_stat & irq_mask);
			wake_o         <= sleep_i & (wake_o | (state == S_ADDR_ACK));
			rx_select_o    <= addr_done & write_hit;
			master_start_o <= (state == S_GEN) & (next_state == S_MHOLD);
		end
	end

	// Checks on the sequencer and its outputs.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_status_no_info: assert property (!ctrl.int_flag |-> status_rd[7:3] == ST_NO_INFO[7:3])
		else $error("status not 0xF8 with flag clear");
	a_addr_ack_code: assert property (ack_done && ctrl.enable && !arb_pend && !berr_evt
		|=> ctrl.int_flag && status_code == ST_ADDR_READ && state == S_WAIT_LOAD)
		else $error("read address match did not report 0xA8");
	a_arb_read_code: assert property (ack_done && ctrl.enable && arb_pend && !berr_evt
		|=> status_code == ST_ARB_READ)
		else $error("lost arbitration read did not report 0xB0");
	a_data_ack_code: assert property (tx_done && ctrl.enable && !berr_evt && master_ack
		&& !last_byte |=> status_code == ST_DATA_ACK && state == S_WAIT_LOAD)
		else $error("acked byte did not report 0xB8");
	a_data_nack_code: assert property (tx_done && ctrl.enable && !berr_evt && !master_ack
		|=> status_code == ST_DATA_NACK && state == S_WAIT_END)
		else $error("nacked byte did not report 0xC0");
	a_last_ack_code: assert property (tx_done && ctrl.enable && !berr_evt && master_ack
		&& last_byte |=> status_code == ST_LAST_ACK && state == S_WAIT_END)
		else $error("ack after last byte did not report 0xC8");
	a_bus_err_flag: assert property (berr_evt
		|=> state == S_BERR && ctrl.int_flag && status_code == ST_BUS_ERR)
		else $error("bus error not flagged with 0x00");
	a_berr_recover: assert property (state == S_BERR && sw_release && ctrl.enable
		|=> state == S_IDLE && !ctrl.stop_request ##1 scl_oe_n_o && sda_oe_n_o)
		else $error("bus error recovery wrong");
	a_wait_holds_scl: assert property (state == S_WAIT_LOAD ##1 state == S_WAIT_LOAD
		|-> !scl_oe_n_o)
		else $error("SCL not held low while waiting");
	a_no_ack_disabled: assert property (addr_done && !ctrl.ack_enable
		|=> state != S_ADDR_ACK)
		else $error("address acknowledged with ack_enable clear");
	a_read_enters_tx: assert property (addr_done && read_hit && ctrl.enable && !start_cond
		|=> state == S_ADDR_ACK ##1 !sda_oe_n_o)
		else $error("read match not acknowledged");
	a_ignore_release: assert property (state == S_IGNORE |=> sda_oe_n_o)
		else $error("SDA driven while not addressed");
	a_msb_first: assert property (state == S_TX |=> sda_oe_n_o == $past(shreg[7]))
		else $error("transmit bit not MSB of shift register");
	a_tx_ack_free: assert property (state == S_TX_ACK |=> sda_oe_n_o)
		else $error("SDA driven in master acknowledge");
	a_start_hold: assert property ($rose(state == S_GEN) && ctrl.enable
		|=> !sda_oe_n_o [*8])
		else $error("generated START not held");
	a_wake_on_match: assert property (state == S_ADDR_ACK && sleep_i |=> wake_o)
		else $error("no wake on match in sleep");
	a_sleep_keeps_data: assert property (sleep_i && !wr_data
		|=> data_reg == $past(data_reg))
		else $error("data register changed by bus in sleep");

	c_read_match: cover property (ack_done ##[1:1000] tx_start);
	c_nack_end: cover property (tx_done && !master_ack);
	c_last_ack: cover property (tx_done && master_ack && last_byte);
	c_bus_error: cover property (berr_evt ##[1:1000] (state == S_BERR && sw_release));

endmodule : ist_slave_tx

// ==== hdl/ist_sync3.sv ====
module ist_sync3 import ist_pkg::*; #(
	parameter int WIDTH = 2
) (
	input  logic             clk_i,
	input  logic             rst_i,
	input  logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	// Three stages per line; a line's output follows once stages two and three agree.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= {WIDTH{1'b1}};
			s2 <= {WIDTH{1'b1}};
			s3 <= {WIDTH{1'b1}};
		end else begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Per-line agreement filter.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_line
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync_o[g] <= 1'b1;
				end else if (s2[g] == s3[g]) begin
					sync_o[g] <= s3[g];
				end
			end
		end
	endgenerate

endmodule : ist_sync3

// ==== tb/ist_master_model.sv ====
module ist_master_model (
	input  wire logic clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Half of the 80 ns link period, in system cycles.
	localparam int HALF = 10;

	// Both lines start released; the pull-ups hold them high.
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Waits half a link period.
	task automatic half();
		repeat (HALF) @(posedge clk_i);
	endtask : half

	// One bit: data moves while SCL is low and is sampled late in the high phase.
	task automatic bit_x(input logic b, output logic r);
		sda_o <= b;
		half();
		scl_o <= 1'b1;
		do @(posedge clk_i); while (scl_i !== 1'b1); // The slave may stretch the clock.
		half();
		r = sda_i;
		scl_o <= 1'b0;
	endtask : bit_x

	// A START is SDA falling while SCL is high.
	task automatic start();
		sda_o <= 1'b1;
		half();
		scl_o <= 1'b1;
		half();
		sda_o <= 1'b0;
		half();
		scl_o <= 1'b0;
	endtask : start

	// A STOP is SDA rising while SCL is high.
	task automatic stop();
		sda_o <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		sda_o <= 1'b1;
		half();
	endtask : stop

	// Sends a byte and returns the slave's acknowledge, low meaning ACK.
	task automatic put(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, ack_n);
	endtask : put

	// Reads a byte and answers with ACK or NACK.
	task automatic get(input logic nack, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			q[i] = r;
		end
		bit_x(nack, r);
	endtask : get
endmodule : ist_master_model

// ==== tb/testbench.sv ====
module testbench import ist_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 20000;
	logic        clk_i, rst_i, cyc, stb, we, sleep_i, arb_lost_i;
	logic [4:0]  adr;
	logic [31:0] wdat, rdat;
	logic        ack, irq, scl_do, scl_oe_n, sda_do, sda_oe_n, wake, m_scl, m_sda, a;
	logic        rxsel, mstart;
	int          n_rxsel = 0;
	int          n_mstart = 0;
	wire logic   scl_w, sda_w;
	logic [6:0]  own;
	logic [7:0]  q;
	int          n_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;

	// Open-drain lines with pull-ups: low while any party pulls.
	assign scl_w = m_scl & (scl_oe_n | scl_do);
	assign sda_w = m_sda & (sda_oe_n | sda_do);

	ist_slave_tx uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq), .scl_i(scl_w), .scl_o(scl_do), .scl_oe_n_o(scl_oe_n),
		.sda_i(sda_w), .sda_o(sda_do), .sda_oe_n_o(sda_oe_n), .sleep_i(sleep_i),
		.arb_lost_i(arb_lost_i), .wake_o(wake), .rx_select_o(rxsel), .master_start_o(mstart));
	ist_master_model m (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl),
		.sda_o(m_sda));

	// The 250 MHz system clock.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Counts the one-cycle hand-off pulses of the receiver and START paths.
	always @(posedge clk_i) begin
		if (rxsel === 1'b1) n_rxsel++;
		if (mstart === 1'b1) n_mstart++;
	end

	// Watchdog: a hang counts as a mismatch and ends the run.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_errors++;
			$display("ERROR %0t: timeout", $time);
			close_out();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One classic Wishbone cycle; read data lands in q at the ack edge.
	task automatic wb(input logic w, input logic [2:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		wb(1'b1, idx, d);
	endtask : wr

	task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00);
		chk(q, exp);
	endtask : rd

	// Polls the status code, prescaler masked, until it leaves the idle code.
	task automatic wait_st(input logic [7:0] exp);
		int k;
		k = 0;
		do begin
			wb(1'b0, ADR_STATUS, 8'h00);
			k++;
		end while ((q & CODE_MASK) === ST_NO_INFO && k < 80);
		chk(q & CODE_MASK, exp);
	endtask : wait_st

	// Status expected after a data byte and the master's answer.
	function automatic logic [7:0] exp_st(input logic last, input logic acked);
		if (!acked) return ST_DATA_NACK;
		return last ? ST_LAST_ACK : ST_DATA_ACK;
	endfunction : exp_st

	// Sends n random bytes, the last marked last, then checks the released bus.
	task automatic xfer(input int n, input logic fin_ack);
		logic [7:0] d, r;
		logic       last, acked;
		for (int i = 0; i < n; i++) begin
			d     = 8'($urandom);
			last  = (i == n - 1);
			acked = !last || fin_ack;
			wr(ADR_DATA, d);
			wr(ADR_CONTROL, last ? 8'h84 : 8'hc4);
			m.get(!acked, r);
			chk(r, d);
			wait_st(exp_st(last, acked));
		end
		wr(ADR_CONTROL, 8'hc4);
		rd(ADR_STATUS, ST_NO_INFO);
		m.get(1'b1, r);
		chk(r, 8'hff);
		m.stop();
	endtask : xfer

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// Main sequence: reset, plain read, lost arbitration in sleep, no match, bus error.
	initial begin
		{rst_i, cyc, stb, we, sleep_i, arb_lost_i} = 6'h20;
		adr  = 5'h00;
		wdat = 32'h0;
		void'($urandom(32'h757e));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(ADR_CONTROL, CTRL_RESET);
		rd(ADR_STATUS, ST_NO_INFO);
		rd(ADR_DATA, DATA_RESET);
		rd(3'h7, 8'h00);
		own = 7'($urandom_range(127, 1));
		wr(ADR_ADDRESS, {own, 1'b1});
		rd(ADR_ADDRESS, {own, 1'b1});
		wr(ADR_IRQ_MASK, 8'h03);
		wr(ADR_CONTROL, 8'h44);
		m.start();
		m.put({own, 1'b1}, a);
		chk(8'(a), 8'h00);
		wait_st(ST_ADDR_READ);
		chk(8'({irq, scl_oe_n}), 8'h02);
		wr(ADR_IRQ_MASK, 8'h00);
		rd(ADR_IRQ_STAT, 8'h01);
		chk(8'(irq), 8'h00);
		wr(ADR_IRQ_STAT, 8'h01);
		wr(ADR_IRQ_MASK, 8'h03);
		rd(ADR_IRQ_STAT, 8'h00);
		chk(8'(irq), 8'h00);
		xfer(3, 1'b0);
		@(posedge clk_i);
		sleep_i    <= 1'b1;
		arb_lost_i <= 1'b1;
		@(posedge clk_i);
		arb_lost_i <= 1'b0;
		m.start();
		m.put({own, 1'b1}, a);
		wait_st(ST_ARB_READ);
		chk(8'(wake), 8'h01);
		sleep_i <= 1'b0;
		xfer(1, 1'b1);
		wr(ADR_CONTROL, 8'h04);
		m.start();
		m.put({own, 1'b1}, a);
		chk(8'(a), 8'h01);
		m.stop();
		rd(ADR_STATUS, ST_NO_INFO);
		wr(ADR_CONTROL, 8'h44);
		m.start();
		m.put({own, 1'b0}, a);
		chk(8'(a), 8'h01);
		m.stop();
		m.start();
		m.put(8'h00, a);
		m.stop();
		chk(8'(n_rxsel), 8'h02);
		m.start();
		for (int i = 6; i > 3; i--) m.bit_x(own[i], a);
		m.stop();
		wait_st(ST_BUS_ERR);
		chk(8'(irq), 8'h01);
		wr(ADR_CONTROL, 8'hd4);
		rd(ADR_CONTROL, 8'h44);
		chk(8'({scl_oe_n, sda_oe_n}), 8'h03);
		wr(ADR_CONTROL, 8'h24);
		repeat (200) @(posedge clk_i);
		chk(8'({scl_oe_n, sda_oe_n}), 8'h00);
		chk(8'(n_mstart), 8'h01);
		wr(ADR_CONTROL, 8'h14);
		repeat (4) @(posedge clk_i);
		chk(8'({scl_oe_n, sda_oe_n}), 8'h03);
		rd(ADR_CONTROL, 8'h04);
		close_out();
	end
endmodule : testbench
